// ---- hdl/vpc_ctrl.sv ----
/*
 * vpc_ctrl: AXI4-Lite register bank for video channel 2 and 3 control bits,
 * driving the channel 2 enable, clock gate, output enables and clip enables.
 * Assumes a single clock mclk and an asynchronous active-low reset rst_n.
 */
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module vpc_ctrl
	import vpc_pkg::*;
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_n,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// axi4-lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// channel 2 controls
	output logic                   chan2_enable,
	output logic                   chan2_clock_enable,
	output logic                   chan2_data_output_enable_low,
	output logic                   chan2_clock_output_enable_low,
	// channel 3 controls
	output logic                   chan3_input_edge_select,
	output logic                   chan3_blanking_clip_enable,
	output logic                   chan3_active_clip_enable
);
	logic              rst_sync1_q;
	logic              rst_sync2_q;
	logic              rst_ok_n;
	logic [31:0]       ch2_ctrl_q;
	logic [31:0]       channel3_control_q;
	logic              aw_held_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic              w_held_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;
	logic              do_write;
	logic [31:0]       strb_mask;
	logic [31:0]       ch2_ctrl_d;
	logic [31:0]       channel3_control_d;
	logic              wr_hit;
	logic [31:0]       rd_value;
	logic              rd_hit;

	// reset release through two flip-flops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync1_q <= 1'b0;
			rst_sync2_q <= 1'b0;
		end else begin
			rst_sync1_q <= 1'b1;
			rst_sync2_q <= rst_sync1_q;
		end
	end
	assign rst_ok_n = rst_sync2_q;

	// address and data accepted independently, one at a time
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;

	// capture write address
	always_ff @(posedge mclk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_q <= 1'b0;
		end
	end

	// capture write data
	always_ff @(posedge mclk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			w_held_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (do_write) begin
			w_held_q <= 1'b0;
		end
	end

	assign do_write = aw_held_q && w_held_q && !bvalid_q;

	// byte-lane mask from strobes
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			strb_mask[i*8 +: 8] = {8{w_strb_q[i]}};
		end
	end

	// next register values, reserved bits forced to zero
	always_comb begin
		ch2_ctrl_d = ch2_ctrl_q;
		channel3_control_d = channel3_control_q;
		wr_hit     = 1'b1;
		if (aw_addr_q[ADDR_W-1:2] == CHANNEL2_CONTROL_OFFSET[ADDR_W-1:2]) begin
			ch2_ctrl_d = ((ch2_ctrl_q & ~strb_mask) | (w_data_q & strb_mask)) & CHANNEL2_CONTROL_MASK;
		end else if (aw_addr_q[ADDR_W-1:2] == CHANNEL3_CONTROL_OFFSET[ADDR_W-1:2]) begin
			channel3_control_d = ((channel3_control_q & ~strb_mask) | (w_data_q & strb_mask)) & CHANNEL3_CONTROL_MASK;
		end else if (aw_addr_q[ADDR_W-1:2] == CHANNEL_STATUS_OFFSET[ADDR_W-1:2]) begin
			wr_hit = 1'b1; // read-only, write ignored
		end else begin
			wr_hit = 1'b0;
		end
	end

	// control registers update at once, no frame-sync holding
	always_ff @(posedge mclk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			ch2_ctrl_q <= CHANNEL2_CONTROL_RESET;
			channel3_control_q <= CHANNEL3_CONTROL_RESET;
		end else if (do_write) begin
			ch2_ctrl_q <= ch2_ctrl_d;
			channel3_control_q <= channel3_control_d;
		end
	end

	// write response
	always_ff @(posedge mclk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// read decode; status word shows the live channel 2 control outputs
	always_comb begin
		rd_value = 32'h0000_0000;
		rd_hit   = 1'b1;
		if (s_axi_araddr[ADDR_W-1:2] == CHANNEL2_CONTROL_OFFSET[ADDR_W-1:2]) begin
			rd_value = ch2_ctrl_q;
		end else if (s_axi_araddr[ADDR_W-1:2] == CHANNEL3_CONTROL_OFFSET[ADDR_W-1:2]) begin
			rd_value = channel3_control_q;
		end else if (s_axi_araddr[ADDR_W-1:2] == CHANNEL_STATUS_OFFSET[ADDR_W-1:2]) begin
			rd_value = {28'h000_0000, chan2_clock_output_enable_low, chan2_data_output_enable_low,
				chan2_clock_enable, chan2_enable};
		end else begin
			rd_hit = 1'b0;
		end
	end

	assign s_axi_arready = !rvalid_q;

	// read response
	always_ff @(posedge mclk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_value;
			rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	// channel 2 controls straight from the register
	assign chan2_enable       = ch2_ctrl_q[CH2_ENABLE_BIT_POS];
	assign chan2_clock_enable = ch2_ctrl_q[CH2_CLOCK_GATE_POS];
	// output enables (active low) follow clock gate, no resync
	assign chan2_data_output_enable_low  = !ch2_ctrl_q[CH2_CLOCK_GATE_POS];
	assign chan2_clock_output_enable_low = !ch2_ctrl_q[CH2_CLOCK_GATE_POS];

	// channel 3 controls exported to the video datapath
	assign chan3_input_edge_select    = channel3_control_q[CH3_EDGE_SELECT_POS];
	assign chan3_blanking_clip_enable = channel3_control_q[CH3_BLANK_CLIP_POS];
	assign chan3_active_clip_enable   = channel3_control_q[CH3_ACTIVE_CLIP_POS];
endmodule : vpc_ctrl

// ---- hdl/vpc_pkg.sv ----
/*
 * vpc_pkg: register map, field positions and reset values of the
 * video port channel control bank.
 * Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
 */
// Functional notes
// - chan2 clock gate bit enables chan2 clock
// - clock gate takes effect immediately, no vsync
// - chan2 output enables follow clock gate directly
// - chan2 enable bit 0 turns channel on
// - chan3 bit 31 selects input data edge
// - edge select only exported, adjusted outside
// - chan3 bit 14 enables blanking clipping
// - chan3 bit 13 zero disables active clipping
// - chan3 bit 13 one enables active clipping
package vpc_pkg;
	localparam int unsigned ADDR_W                  = 12;
	localparam logic [11:0] CHANNEL2_CONTROL_OFFSET = 12'h000;
	localparam logic [11:0] CHANNEL3_CONTROL_OFFSET = 12'h004;
	localparam logic [11:0] CHANNEL_STATUS_OFFSET   = 12'h008;
	localparam int unsigned CH2_ENABLE_BIT_POS      = 0;
	localparam int unsigned CH2_CLOCK_GATE_POS      = 1;
	localparam int unsigned CH3_EDGE_SELECT_POS     = 31;
	localparam int unsigned CH3_BLANK_CLIP_POS      = 14;
	localparam int unsigned CH3_ACTIVE_CLIP_POS     = 13;
	localparam logic [31:0] CHANNEL2_CONTROL_RESET  = 32'h0000_0000;
	localparam logic [31:0] CHANNEL3_CONTROL_RESET  = 32'h0000_0000;
	localparam logic [31:0] CHANNEL2_CONTROL_MASK   = 32'h0000_0003;
	localparam logic [31:0] CHANNEL3_CONTROL_MASK   = 32'h8000_6000;
	localparam logic [1:0]  RESP_OKAY               = 2'h0;
	localparam logic [1:0]  RESP_SLVERR             = 2'h2;
endpackage : vpc_pkg

// ---- bench/vpc_ctrl_asserts.sv ----
/* vpc_ctrl_asserts: port checks for the channel control bank.
   Assumes it is bound to vpc_ctrl and uses the vpc_pkg register map. */
`timescale 1ns/1ps
module vpc_chk
	import vpc_pkg::*;
(
	// bus side
	input wire logic              mclk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [31:0]       s_axi_wdata,
	input wire logic [3:0]        s_axi_wstrb,
	// control outputs
	input wire logic              chan2_enable, chan2_clock_enable, chan2_data_output_enable_low,
	input wire logic              chan2_clock_output_enable_low, chan3_input_edge_select,
	input wire logic              chan3_blanking_clip_enable, chan3_active_clip_enable
);
	logic [ADDR_W-1:0] a_q;
	logic [31:0]       d_q;
	logic [3:0]        s_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// keep the last taken write address and data
	always_ff @(posedge mclk) begin
		if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) d_q <= s_axi_wdata;
		if (s_axi_wvalid && s_axi_wready) s_q <= s_axi_wstrb;
	end
	sequence c2_wr; $rose(s_axi_bvalid) && a_q == CHANNEL2_CONTROL_OFFSET; endsequence
	sequence c3_wr; $rose(s_axi_bvalid) && a_q == CHANNEL3_CONTROL_OFFSET; endsequence
	chan_enable_a: assert property (c2_wr and s_q[0] |-> chan2_enable == d_q[0])
		else $error("channel enable mismatch");
	clock_gate_a: assert property (c2_wr and s_q[0] |-> chan2_clock_enable == d_q[1])
		else $error("clock gate mismatch");
	data_oe_a: assert property (chan2_data_output_enable_low == !chan2_clock_enable)
		else $error("data output enable mismatch");
	clock_oe_a: assert property (chan2_clock_output_enable_low == !chan2_clock_enable)
		else $error("clock output enable mismatch");
	edge_select_a: assert property (c3_wr and s_q[3] |-> chan3_input_edge_select == d_q[31])
		else $error("edge select mismatch");
	blank_clip_a: assert property (c3_wr and s_q[1] |-> chan3_blanking_clip_enable == d_q[14])
		else $error("blanking clip mismatch");
	active_clip_a: assert property (c3_wr and s_q[1] |-> chan3_active_clip_enable == d_q[13])
		else $error("active clip mismatch");
	no_lag_a: assert property ($changed({chan2_enable, chan2_clock_enable, chan3_input_edge_select,
		chan3_blanking_clip_enable, chan3_active_clip_enable}) |-> $rose(s_axi_bvalid))
		else $error("control changed outside a write");
	cover property (c2_wr);
	cover property (c3_wr);
	cover property ($rose(chan2_clock_enable));
endmodule : vpc_chk
bind vpc_ctrl vpc_chk vpc_chk_i (.*);

// ---- bench/vpc_ctrl_tb.sv ----
/* vpc_ctrl_tb: register-level test of the channel control bank.
   Assumes vpc_ctrl with a 100 ns mclk and the vpc_pkg map. */
`timescale 1ns/1ps
module vpc_ctrl_tb;
	import vpc_pkg::*;
	logic              mclk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic              s_axi_bready = 1, s_axi_rready = 1;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]       s_axi_wdata = '0, s_axi_rdata, v, x;
	logic [3:0]        s_axi_wstrb = 4'hF;
	logic [1:0]        s_axi_bresp, s_axi_rresp, r;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic              chan2_enable, chan2_clock_enable, chan2_data_output_enable_low;
	logic              chan2_clock_output_enable_low, chan3_input_edge_select;
	logic              chan3_blanking_clip_enable, chan3_active_clip_enable;
	int                fail_count = 0, total_checks = 0, cyc = 0;
	logic [31:0]       c2v[5] = '{32'h0, 32'h2, 32'h3, 32'h2, 32'h0};
	logic [31:0]       c3v[5] = '{32'hFFFF_FFFF, 32'h8000_0000, 32'h4000, 32'h2000, 32'h0};
	vpc_ctrl vpc_ctrl_i (.*);
	// clock
	initial forever #50 mclk = ~mclk;
	task automatic give_verdict;
		if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		x = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd
	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 1000) begin
			fail_count++;
			give_verdict();
		end
	end
	// main sequence
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(CHANNEL3_CONTROL_OFFSET);
		chk(x, CHANNEL3_CONTROL_RESET);
		foreach (c2v[i]) begin
			v = c2v[i];
			wr(CHANNEL2_CONTROL_OFFSET, v);
			chk(r, RESP_OKAY);
			chk({chan2_clock_enable, chan2_enable}, v[1:0]);
			chk({chan2_data_output_enable_low, chan2_clock_output_enable_low}, {2{~v[1]}});
			rd(CHANNEL_STATUS_OFFSET);
			chk(x, {28'h0, {2{~v[1]}}, v[1:0]});
		end
		foreach (c3v[i]) begin
			v = c3v[i];
			wr(CHANNEL3_CONTROL_OFFSET, v);
			chk({chan3_input_edge_select, chan3_blanking_clip_enable, chan3_active_clip_enable}, {v[31], v[14:13]});
			rd(CHANNEL3_CONTROL_OFFSET);
			chk(x, v & CHANNEL3_CONTROL_MASK);
		end
		// unmapped place refuses and changes nothing
		wr(12'h010, 32'hFFFF_FFFF);
		chk(r, RESP_SLVERR);
		rd(12'h010);
		chk(r, RESP_SLVERR);
		chk(x, 32'h0000_0000);
		chk(chan2_enable, 1'b0);
		chk({chan3_input_edge_select, chan3_blanking_clip_enable, chan3_active_clip_enable}, 32'h0);
		give_verdict();
	end
endmodule : vpc_ctrl_tb
